//--- rtl/iscd_regs.svh
// field positions and encodings for the integer and simd class decoder
`ifndef ISCD_REGS_SVH
`define ISCD_REGS_SVH
`define ISCD_WIDE_POS     31
`define ISCD_VARIANT_POS  30
`define ISCD_FLAGS_POS    29
`define ISCD_MAJ_HI       31
`define ISCD_MAJ_LO       28
`define ISCD_MIN_HI       24
`define ISCD_MIN_LO       23
`define ISCD_SEC_HI       22
`define ISCD_SEC_LO       19
`define ISCD_LOW_HI       18
`define ISCD_LOW_LO       10
`define ISCD_SHIFT_RSV    2'h3
`define ISCD_EXT_OK       2'h0
`define ISCD_DP_REG       4'h5
`define ISCD_SIMD_GRP     3'h7
`endif

//--- rtl/iscd_pkg.sv
// types for the integer and simd class decoder
package iscd_pkg;
	typedef enum logic [5:0] {
		ISCD_OP_NONE        = 6'h00,
		ISCD_OP_ADD         = 6'h01,
		ISCD_OP_ADD_SET     = 6'h02,
		ISCD_OP_SUB         = 6'h03,
		ISCD_OP_SUB_SET     = 6'h04,
		ISCD_OP_ADC         = 6'h05,
		ISCD_OP_ADC_SET     = 6'h06,
		ISCD_OP_SBC         = 6'h07,
		ISCD_OP_SBC_SET     = 6'h08,
		ISCD_OP_COND_COMPARE_NEGATIVE        = 6'h09,
		ISCD_OP_COND_COMPARE        = 6'h0a,
		ISCD_OP_PICK        = 6'h0b,
		ISCD_OP_PICK_INC    = 6'h0c,
		ISCD_OP_PICK_INV    = 6'h0d,
		ISCD_OP_PICK_NEG    = 6'h0e,
		ISCD_OP_ROT_FLAGS   = 6'h0f,
		ISCD_OP_S_COPY      = 6'h10,
		ISCD_OP_S_FP16_3S   = 6'h11,
		ISCD_OP_S_FP16_2M   = 6'h12,
		ISCD_OP_S_PAIRWISE  = 6'h13,
		ISCD_OP_S_3DIFF     = 6'h14,
		ISCD_OP_S_3SAME     = 6'h15,
		ISCD_OP_S_SHIFT_IMM = 6'h16,
		ISCD_OP_S_INDEXED   = 6'h17,
		ISCD_OP_V_FP16_3S   = 6'h18,
		ISCD_OP_V_ACROSS    = 6'h19
	} iscd_op_t;
	typedef enum logic [1:0] {
		ISCD_FORM_SHIFTED = 2'h0,
		ISCD_FORM_EXTENDED = 2'h1,
		ISCD_FORM_OTHER   = 2'h3
	} iscd_form_t;
	typedef struct packed {
		logic       valid;
		logic       undef;
		iscd_op_t   op;
		logic       wide;
		logic       set_flags;
		iscd_form_t form;
	} iscd_dec_t;
	typedef struct packed {
		logic        issue_valid;
		iscd_dec_t   dec;
		logic [31:0] word;
	} iscd_state_t;
endpackage : iscd_pkg

//--- rtl/iscd_simd_class.sv
// sorts simd words into scalar and vector subgroups
`timescale 1ns/10ps
`include "iscd_regs.svh"
module iscd_simd_class
	import iscd_pkg::*;
(
	// instruction
	input  wire logic [31:0] word,
	// result
	output iscd_op_t         op,
	output logic             rsvd
);
	logic [3:0] maj;
	logic [1:0] mnr;
	logic [3:0] sec;
	logic [8:0] low;
	assign maj = word[`ISCD_MAJ_HI:`ISCD_MAJ_LO];
	assign mnr = word[`ISCD_MIN_HI:`ISCD_MIN_LO];
	assign sec = word[`ISCD_SEC_HI:`ISCD_SEC_LO];
	assign low = word[`ISCD_LOW_HI:`ISCD_LOW_LO];
	always_comb begin
		op   = ISCD_OP_NONE;
		rsvd = 1'b0;
		if (maj[3:2] == 2'b01 && maj[0]) begin
			if (!mnr[1]) begin
				if (sec[3:2] == 2'b00 && !low[5] && low[0]) begin
					if (mnr[0]) rsvd = 1'b1;
					else op = ISCD_OP_S_COPY;
				end else if (sec[3:2] == 2'b10 && low[5:4] == 2'b00 && low[0]) begin
					op = ISCD_OP_S_FP16_3S;
				end else if (sec[3:2] == 2'b10 && low[5:4] == 2'b01 && low[0]) begin
					rsvd = 1'b1;
				end else if (low[8:7] == 2'b00 && low[1:0] == 2'b10 && sec == 4'hf) begin
					op = ISCD_OP_S_FP16_2M;
				end else if (low[8:7] == 2'b00 && low[1:0] == 2'b10 && sec == 4'h7) begin
					rsvd = 1'b1;
				end else if (low[8:7] == 2'b00 && low[1:0] == 2'b10 && sec[2:0] == 3'h6) begin
					op = ISCD_OP_S_PAIRWISE;
				end else if (sec[2] && low[1:0] == 2'b00) begin
					op = ISCD_OP_S_3DIFF;
				end else if (sec[2] && low[0]) begin
					op = ISCD_OP_S_3SAME;
				end
			end else if (low[0]) begin
				if (mnr[0]) rsvd = 1'b1;
				else op = ISCD_OP_S_SHIFT_IMM;
			end else begin
				op = ISCD_OP_S_INDEXED;
			end
		end else if (!maj[3] && !maj[0] && !mnr[1]) begin
			if (sec[3:2] == 2'b10 && low[5:4] == 2'b00 && low[0]) begin
				op = ISCD_OP_V_FP16_3S;
			end else if (sec[2:0] == 3'h6 && low[8:7] == 2'b00 && low[1:0] == 2'b10) begin
				op = ISCD_OP_V_ACROSS;
			end
		end
	end
endmodule : iscd_simd_class

//--- rtl/iscd_decode.sv
// integer and simd class decode stage
// Summary of operation
// - shifted add/sub: width, subtract, flags from bits; reject shift 11, narrow amount 1xxxxx
// - extended add/sub: option 00 only; reject extend shift 1x1 or 11x
// - carry add/sub: all eight width, subtract, flag combinations valid
// - rotate into flags: reject narrow, subtract, no flags, or compare-form set
// - register conditional compare: reject reserved, compare-form, or clear flag bit
// - immediate conditional compare: same rejects; variant and width as register form
// - conditional pick: reject select-variant 1x or flags set; four ops, two widths
// - scalar copy when minor 00; minor 01 reserved
// - scalar half-precision three-same; low xxx01xxx1 reserved
// - scalar half-precision two-register misc; secondary 0111 reserved
// - scalar pairwise class
// - scalar three-different on low ending 00, three-same on ending 1
// - scalar shift by immediate on minor 10; minor 11 reserved
// - scalar by-indexed-element on minor 1x and low ending 0
// - vector half-precision three-same
// - vector across-lanes class
`timescale 1ns/10ps
`include "iscd_regs.svh"
module iscd_decode
	import iscd_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// from fetch
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_word,
	// to execute control
	output logic             issue_valid,
	output iscd_dec_t        issue_dec,
	output logic [31:0]      issue_word,
	// to exception handling
	output logic             undef_insn
);
	iscd_state_t state;
	iscd_state_t next_state;
	iscd_op_t    simd_op;
	logic        simd_rsvd;
	iscd_dec_t   dec;
	logic        w;
	logic        v;
	logic        s;
	logic [31:0] x;

	iscd_simd_class u_simd (
		.word (fetch_word),
		.op   (simd_op),
		.rsvd (simd_rsvd)
	);

	assign x = fetch_word;
	assign w = x[`ISCD_WIDE_POS];
	assign v = x[`ISCD_VARIANT_POS];
	assign s = x[`ISCD_FLAGS_POS];

	always_comb begin
		dec           = '0;
		dec.op        = ISCD_OP_NONE;
		dec.form      = ISCD_FORM_OTHER;
		dec.wide      = w;
		dec.set_flags = s;
		if (x[27:25] == 3'(`ISCD_DP_REG) && !x[28] && x[24]) begin
			if (!x[21]) begin
				dec.form = ISCD_FORM_SHIFTED;
				if (x[23:22] != `ISCD_SHIFT_RSV && !(!w && x[15])) begin
					dec.op = v ? (s ? ISCD_OP_SUB_SET : ISCD_OP_SUB)
					           : (s ? ISCD_OP_ADD_SET : ISCD_OP_ADD);
				end
			end else begin
				dec.form = ISCD_FORM_EXTENDED;
				if (x[23:22] == `ISCD_EXT_OK && !(x[12] && x[10]) && x[12:11] != 2'b11) begin
					dec.op = v ? (s ? ISCD_OP_SUB_SET : ISCD_OP_SUB)
					           : (s ? ISCD_OP_ADD_SET : ISCD_OP_ADD);
				end
			end
		end else if (x[27:25] == 3'(`ISCD_DP_REG) && x[28] && x[24:21] == 4'h0) begin
			if (x[15:10] == 6'h00) begin
				dec.op = v ? (s ? ISCD_OP_SBC_SET : ISCD_OP_SBC)
				           : (s ? ISCD_OP_ADC_SET : ISCD_OP_ADC);
			end else if (x[14:10] == 5'h01) begin
				if (w && !v && s && !x[4]) dec.op = ISCD_OP_ROT_FLAGS;
			end
		end else if (x[27:25] == 3'(`ISCD_DP_REG) && x[28] && x[24:21] == 4'h2) begin
			if (!x[4] && !x[10] && s) begin
				dec.op = v ? ISCD_OP_COND_COMPARE : ISCD_OP_COND_COMPARE_NEGATIVE;
			end
		end else if (x[27:25] == 3'(`ISCD_DP_REG) && x[28] && x[24:21] == 4'h4) begin
			if (!x[11] && !s) begin
				case ({v, x[10]})
					2'b00: dec.op = ISCD_OP_PICK;
					2'b01: dec.op = ISCD_OP_PICK_INC;
					2'b10: dec.op = ISCD_OP_PICK_INV;
					default: dec.op = ISCD_OP_PICK_NEG;
				endcase
			end
		end else if (x[27:25] == `ISCD_SIMD_GRP) begin
			dec.wide      = 1'b0;
			dec.set_flags = 1'b0;
			if (!simd_rsvd) dec.op = simd_op;
		end
		dec.valid = (dec.op != ISCD_OP_NONE);
		dec.undef = !dec.valid;
	end

	always_comb begin
		next_state = state;
		if (clk_en) begin
			next_state.issue_valid = fetch_valid && dec.valid;
			next_state.dec         = fetch_valid ? dec : '0;
			next_state.dec.undef   = fetch_valid && dec.undef;
			next_state.word        = fetch_word;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign issue_valid = state.issue_valid;
	assign issue_dec   = state.dec;
	assign issue_word  = state.word;
	assign undef_insn  = state.dec.undef;
endmodule : iscd_decode

//--- sim/iscd_decode_props.sv
// assertions for the class decode stage
`timescale 1ns/10ps
module iscd_decode_props
	import iscd_pkg::*;
(
	// watched ports
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        clk_en,
	input wire logic        fetch_valid,
	input wire logic [31:0] fetch_word,
	input wire logic        issue_valid,
	input wire iscd_dec_t   issue_dec,
	input wire logic [31:0] issue_word,
	input wire logic        undef_insn
);
	logic [31:0] w;
	logic        t, sh, ex, cr, cc, pk;
	assign w = fetch_word;
	assign t = clk_en & fetch_valid;
	assign sh = t & w[28:24] == 5'h0b & !w[21];
	assign ex = t & w[28:24] == 5'h0b & w[21];
	assign cr = t & w[28:21] == 8'hd0;
	assign cc = t & w[28:21] == 8'hd2;
	assign pk = t & w[28:21] == 8'hd4;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_shift_rsv: assert property (sh & (w[23:22] == 2'h3 | !w[31] & w[15]) |=> undef_insn)
		else $error("reserved shifted word issued");
	a_shift_op: assert property (sh & w[23:22] != 2'h3 & !w[15] |=>
		issue_dec.op == 6'h01 + $past(w[30:29]) & issue_dec.wide == $past(w[31]))
		else $error("shifted op wrong");
	a_ext_opt: assert property (ex & (w[23:22] != 2'h0 | w[12:10] > 3'h4) |=> undef_insn)
		else $error("reserved extended word issued");
	a_carry_map: assert property (cr & w[15:10] == 6'h00 |=>
		issue_dec.op == 6'h05 + $past(w[30:29]) & issue_dec.set_flags == $past(w[29]))
		else $error("carry op wrong");
	a_rot_rsv: assert property (cr & w[14:10] == 5'h01 &
		(w[30:29] != 2'h1 | !w[31] | w[4]) |=> undef_insn) else $error("rotate not refused");
	a_cmp_rsv: assert property (cc & (w[10] | w[4] | !w[29]) |=> undef_insn)
		else $error("compare not refused");
	a_cmp_op: assert property (cc & !w[10] & !w[4] & w[29] |=>
		issue_dec.op == ($past(w[30]) ? ISCD_OP_COND_COMPARE : ISCD_OP_COND_COMPARE_NEGATIVE)) else $error("compare op");
	a_pick_rsv: assert property (pk & (w[11] | w[29]) |=> undef_insn)
		else $error("pick not refused");
	a_undef_excl: assert property (undef_insn |-> !issue_valid)
		else $error("refused word issued");
endmodule : iscd_decode_props
bind iscd_decode iscd_decode_props u_iscd_decode_props (.clk(clk), .rst_n(rst_n),
	.clk_en(clk_en), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
	.issue_valid(issue_valid), .issue_dec(issue_dec), .issue_word(issue_word),
	.undef_insn(undef_insn));

//--- sim/iscd_fetch_model.sv
// fetch side model, one word a cycle
`timescale 1ns/10ps
module iscd_fetch_model (
	// from bench
	input wire logic        clk,
	input wire logic        go,
	input wire logic [31:0] word,
	// to decoder
	output logic            fetch_valid,
	output logic [31:0]     fetch_word
);
	initial fetch_valid = 1'b0;
	initial fetch_word = 32'h0;
	// idle word flips so a stale word never looks valid
	always @(negedge clk) begin
		fetch_valid <= go;
		fetch_word <= go ? word : ~fetch_word;
	end
endmodule : iscd_fetch_model

//--- sim/tb.sv
// self-checking bench for the class decode stage
`timescale 1ns/10ps
module tb;
	import iscd_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        go = 1'b0;
	logic [31:0] word = 32'h0;
	logic        fetch_valid, issue_valid, undef_insn;
	logic [31:0] fetch_word, issue_word;
	iscd_dec_t   issue_dec;
	int          miscompares = 0;
	int          num_checks = 0;
	always #25 clk = ~clk;
	iscd_fetch_model u_iscd_fetch_model (.clk(clk), .go(go), .word(word),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word));
	iscd_decode u_iscd_decode (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.fetch_valid(fetch_valid), .fetch_word(fetch_word), .issue_valid(issue_valid),
		.issue_dec(issue_dec), .issue_word(issue_word), .undef_insn(undef_insn));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	// op 00 means the word must be refused
	task automatic send(input logic [37:0] v);
		#1;
		go = 1'b1;
		word = v[31:0];
		repeat (2) @(negedge clk);
		check({30'h0, issue_valid, undef_insn}, {30'h0, v[37:32] != 0, v[37:32] == 0});
		check({26'h0, issue_dec.op}, {26'h0, v[37:32]});
		if (v[37:32] != 6'h00) begin
			check(issue_word, v[31:0]);
		end
		if (v[37:32] != 6'h00 && v[37:32] < 6'h10) begin
			check({31'h0, issue_dec.wide}, {31'h0, v[31]});
			check({31'h0, issue_dec.set_flags}, {31'h0, v[29]});
		end
	endtask : send
	task scen_addsub;
		logic [37:0] t[7] = '{38'h04eb000000, 38'h006bc00000, 38'h002b008000,
			38'h022b000000, 38'h018b200000, 38'h000b201400, 38'h000b600000};
		foreach (t[i]) send(t[i]);
		for (int i = 0; i < 8; i++) send({6'h05 + 6'(i % 4), 3'(i), 29'h1a000000});
	endtask : scen_addsub
	task scen_flags;
		logic [37:0] t[16] = '{38'h0fba000400, 38'h003a000400, 38'h00fa000400,
			38'h009a000400, 38'h00ba000410, 38'h0afa400000, 38'h093a400800, 38'h00ba400400,
			38'h00fa400810, 38'h00da400000, 38'h0b1a800000, 38'h0c1a800400, 38'h0d5a800000,
			38'h0eda800400, 38'h001a800800, 38'h003a800000};
		foreach (t[i]) send(t[i]);
	endtask : scen_flags
	task scen_simd;
		logic [37:0] t[16] = '{38'h105e000400, 38'h005e800400, 38'h115e400400,
			38'h005e404400, 38'h125e780800, 38'h005e380800, 38'h135e300800, 38'h145e200000,
			38'h155e200400, 38'h165f000400, 38'h005f800400, 38'h175f000000, 38'h180e400400,
			38'h190e300800, 38'h004e280800, 38'h0b1a800000};
		foreach (t[i]) send(t[i]);
	endtask : scen_simd
	task scen_hold;
		send(38'h018b200000);
		clk_en = 1'b0;
		#1;
		word = 32'h5e000400;
		repeat (2) @(negedge clk);
		check(issue_word, 32'h8b200000);
		clk_en = 1'b1;
		@(negedge clk);
		check(issue_word, 32'h5e000400);
		#1;
		go = 1'b0;
		repeat (2) @(negedge clk);
		check({30'h0, issue_valid, undef_insn}, 32'h0);
	endtask : scen_hold
	task results;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		scen_addsub;
		scen_flags;
		scen_simd;
		scen_hold;
		results;
	end
endmodule : tb
